/* src/abr_conv_timer.v */
// Purpose: paces conversions and pulses when each result is ready
// Assumes: start is a one-cycle pulse; a new start restarts the count
// Notes: temperature channel doubles every interval
`include "abr_map.vh"
module abr_conv_timer #(
  parameter [14:0] FIRST_CYCLES = {1'b0, `ABR_CONV_FIRST}, // initial conversion length
  parameter [14:0] REPEAT_CYCLES = {1'b0, `ABR_CONV_REPEAT} // continuous refresh
) (
  input wire clock, // system clock
  input wire arst_n, // async reset, active low
  input wire start, // begin or restart a conversion
  input wire repeat_mode, // keep converting
  input wire temp_sensor, // temperature channel, double time
  output reg busy, // conversion in progress
  output reg done, // one-cycle pulse, result ready
  output reg first_done // at least one result since start
);
  reg [15:0] count;
  reg [15:0] next_count;

  function [15:0] interval;
    input [14:0] base;
    input dbl;
    begin
      interval = dbl ? {base, 1'b0} : {1'b0, base};
    end
  endfunction

  always @* begin
    next_count = count - 16'h0001;
    if (start)
      next_count = interval(FIRST_CYCLES, temp_sensor);
    else if (count == 16'h0001 && repeat_mode)
      next_count = interval(REPEAT_CYCLES, temp_sensor);
    else if (count == 16'h0000 || !busy)
      next_count = 16'h0000;
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
      first_done <= 1'b0;
    end else begin
      count <= next_count;
      done <= busy && !start && count == 16'h0001;
      if (start) begin
        busy <= 1'b1;
        first_done <= 1'b0;
      end else if (busy && count == 16'h0001) begin
        busy <= repeat_mode;
        first_done <= 1'b1;
      end
    end
  end
endmodule

/* src/abr_map.vh */
// Purpose: register offsets, field positions, reset values and timing for the converter block
// Assumes: 12-bit register address space, 8-bit data
// Notes: included by every design file of the block
`ifndef ABR_MAP_VH
`define ABR_MAP_VH
`define ABR_ADDR_CTRL0 12'hf70
`define ABR_ADDR_CTRL1 12'hf71
`define ABR_ADDR_RES_HI 12'hf72
`define ABR_ADDR_RES_LO 12'hf73
`define ABR_ADDR_PWR 12'hf74
`define ABR_CTRL0_RESET 7'h00
`define ABR_CTRL1_RESET 8'h80
`define ABR_PWR_RESET 2'h1
`define ABR_CTRL1_WMASK 8'h87
`define ABR_BIT_START 7
`define ABR_BIT_REF_LOW 6
`define ABR_BIT_REPEAT 4
`define ABR_BIT_REF_HIGH 7
`define ABR_BIT_LP_AMP_N 0
`define ABR_BIT_STOP_EN 1
`define ABR_CH_TEMP 4'he
`define ABR_CONV_FIRST 14'h1409
`define ABR_CONV_REPEAT 14'h0100
`define ABR_BUF_SE_UNBUF 3'h0
`define ABR_BUF_SE_BUF 3'h1
`define ABR_BUF_DI_UNBUF 3'h4
`define ABR_BUF_DI_BUF 3'h5
`define ABR_REF_EXT 2'h0
`define ABR_REF_1V0 2'h1
`define ABR_REF_2V0 2'h2
`endif

/* src/abr_mode_decode.v */
// Purpose: decodes buffer mode, reference code and channel select into analog controls
// Assumes: all inputs are registered values from the control registers
// Notes: reserved buffer codes disable every input switch
`include "abr_map.vh"
module abr_mode_decode (
  input wire [2:0] input_buffer_select, // buffer mode field
  input wire ref_level_high_bit, // reference code upper bit
  input wire ref_level_low_bit, // reference code lower bit
  input wire [3:0] analog_channel_select, // channel field
  output reg buf_valid, // buffer code is not reserved
  output reg buf_diff, // differential pair selected
  output reg buf_unity, // unity-gain buffer in path
  output reg ref_external, // reference from pin
  output reg ref_int_1v0, // internal 1.0 V reference
  output reg ref_int_2v0, // internal 2.0 V reference
  output reg [15:0] se_switch, // single-ended switch, one-hot
  output reg [15:0] diff_switch // differential switch, one-hot
);
  always @* begin
    buf_valid = 1'b1;
    buf_diff = 1'b0;
    buf_unity = 1'b0;
    case (input_buffer_select)
      `ABR_BUF_SE_UNBUF: begin
      end
      `ABR_BUF_SE_BUF: buf_unity = 1'b1;
      `ABR_BUF_DI_UNBUF: buf_diff = 1'b1;
      `ABR_BUF_DI_BUF: begin
        buf_diff = 1'b1;
        buf_unity = 1'b1;
      end
      default: buf_valid = 1'b0;
    endcase
  end

  always @* begin
    ref_external = 1'b0;
    ref_int_1v0 = 1'b0;
    ref_int_2v0 = 1'b0;
    case ({ref_level_high_bit, ref_level_low_bit})
      `ABR_REF_EXT: ref_external = 1'b1;
      `ABR_REF_1V0: ref_int_1v0 = 1'b1;
      `ABR_REF_2V0: ref_int_2v0 = 1'b1;
      default: ref_external = 1'b0;
    endcase
  end

  // one table or the other, never both, so pins cannot be shorted
  always @* begin
    se_switch = 16'h0000;
    diff_switch = 16'h0000;
    if (buf_valid && !buf_diff)
      se_switch[analog_channel_select] = 1'b1;
    else if (buf_valid)
      diff_switch[analog_channel_select] = 1'b1;
  end
endmodule

/* src/abr_top.v */
// Purpose: control, result and amplifier-enable registers of the on-chip converter
// Assumes: plain register port, read data in the cycle after the read strobe
// Notes: the analog core hands back a 13-bit sample and overflow, taken on the conversion timer's done pulse
//
// Our own choice: strobed register access.
`include "abr_map.vh"
module abr_top #(
  parameter [14:0] FIRST_CYCLES = {1'b0, `ABR_CONV_FIRST}, // initial conversion clocks
  parameter [14:0] REPEAT_CYCLES = {1'b0, `ABR_CONV_REPEAT} // refresh clocks
) (
  input wire clock, // 125 MHz system clock
  input wire arst_n, // async reset, active low
  input wire [11:0] reg_addr, // register address
  input wire [7:0] reg_wdata, // write data
  input wire reg_write, // write strobe
  input wire reg_read, // read strobe
  output reg [7:0] reg_rdata, // read data, cycle after strobe
  input wire [12:0] sample_data, // converter core sample
  input wire sample_ovf, // core overflow for that sample
  input wire stop_mode, // chip is in stop mode
  output wire conv_busy, // conversion running
  output wire sample_req, // core starts sampling
  output wire low_power_amp_on, // amplifier power
  output wire [2:0] input_buffer_select, // buffer mode to analog
  output wire buf_unity, // unity-gain buffer in path
  output wire buf_diff, // differential input
  output wire ref_external, // external reference
  output wire ref_int_1v0, // internal 1.0 V
  output wire ref_int_2v0, // internal 2.0 V
  output wire [15:0] se_switch, // single-ended switches
  output wire [15:0] diff_switch // differential switches
);
  reg [6:0] ctrl0;
  reg [7:0] ctrl1;
  reg [1:0] power_control_zero;
  reg [12:0] result_live;
  reg live_ovf;
  reg [7:0] result_upper_byte;
  reg [4:0] result_lower_bits;
  reg sample_overflow_flag;
  reg [7:0] next_rdata;
  wire start_pulse;
  wire conv_done;
  wire [3:0] conv_channel;

  function hit;
    input [11:0] addr;
    input [11:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  assign start_pulse = reg_write && hit(reg_addr, `ABR_ADDR_CTRL0) && reg_wdata[`ABR_BIT_START];
  assign sample_req = start_pulse;
  // a start write carries its own channel; the stored field is still the old one
  assign conv_channel = start_pulse ? reg_wdata[3:0] : ctrl0[3:0];
  assign input_buffer_select = ctrl1[2:0];
  // amplifier bit is active low; stop mode does not gate it
  assign low_power_amp_on = !power_control_zero[`ABR_BIT_LP_AMP_N];

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl0 <= `ABR_CTRL0_RESET;
      ctrl1 <= `ABR_CTRL1_RESET;
      power_control_zero <= `ABR_PWR_RESET;
    end else if (reg_write) begin
      if (hit(reg_addr, `ABR_ADDR_CTRL0))
        ctrl0 <= reg_wdata[6:0];
      if (hit(reg_addr, `ABR_ADDR_CTRL1))
        ctrl1 <= reg_wdata & `ABR_CTRL1_WMASK;
      if (hit(reg_addr, `ABR_ADDR_PWR))
        power_control_zero <= reg_wdata[1:0];
    end
  end

  // result storage has no reset by design
  always @(posedge clock) begin
    if (conv_done) begin
      result_live <= sample_data;
      live_ovf <= sample_ovf;
    end
    if (reg_read && hit(reg_addr, `ABR_ADDR_RES_HI)) begin
      result_lower_bits <= result_live[4:0];
      sample_overflow_flag <= live_ovf;
    end
  end

  always @* begin
    result_upper_byte = result_live[12:5];
    case (reg_addr)
      `ABR_ADDR_CTRL0: next_rdata = {conv_busy, ctrl0};
      `ABR_ADDR_CTRL1: next_rdata = ctrl1;
      // no write path exists for results
      `ABR_ADDR_RES_HI: next_rdata = result_upper_byte;
      `ABR_ADDR_RES_LO: next_rdata = {result_lower_bits, 2'h0, sample_overflow_flag};
      `ABR_ADDR_PWR: next_rdata = {6'h00, power_control_zero};
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end

  abr_conv_timer #(
    .FIRST_CYCLES(FIRST_CYCLES),
    .REPEAT_CYCLES(REPEAT_CYCLES)
  ) u_timer (
    .clock(clock),
    .arst_n(arst_n),
    .start(start_pulse),
    .repeat_mode(ctrl0[`ABR_BIT_REPEAT]),
    .temp_sensor(!buf_diff && conv_channel == `ABR_CH_TEMP),
    .busy(conv_busy),
    .done(conv_done),
    .first_done()
  );

  abr_mode_decode u_decode (
    .input_buffer_select(ctrl1[2:0]),
    .ref_level_high_bit(ctrl1[`ABR_BIT_REF_HIGH]),
    .ref_level_low_bit(ctrl0[`ABR_BIT_REF_LOW]),
    .analog_channel_select(ctrl0[3:0]),
    .buf_valid(),
    .buf_diff(buf_diff),
    .buf_unity(buf_unity),
    .ref_external(ref_external),
    .ref_int_1v0(ref_int_1v0),
    .ref_int_2v0(ref_int_2v0),
    .se_switch(se_switch),
    .diff_switch(diff_switch)
  );
endmodule

/* verification/abr_top_checker.sv */
// Purpose: port-level checks of the converter register block
// Assumes: one clock domain, async active-low reset
// Notes: bound from the bench top file
module abr_top_checker #(
  parameter [14:0] FIRST_CYCLES = 15'h0014, // initial count
  parameter [14:0] REPEAT_CYCLES = 15'h0004 // refresh count
) (
  input wire logic clock, // clock
  input wire logic arst_n, // reset
  input wire logic [11:0] reg_addr, // address
  input wire logic [7:0] reg_wdata, // wdata
  input wire logic reg_write, // write
  input wire logic reg_read, // read
  input wire logic [7:0] reg_rdata, // rdata
  input wire logic conv_busy, // busy
  input wire logic sample_req, // start
  input wire logic low_power_amp_on, // amp
  input wire logic [2:0] input_buffer_select, // mode
  input wire logic buf_unity, // unity
  input wire logic buf_diff, // diff
  input wire logic ref_external, // ref pin
  input wire logic ref_int_1v0, // 1.0 V
  input wire logic ref_int_2v0 // 2.0 V
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_start;
    reg_write && reg_addr == 12'hf70 && reg_wdata[7];
  endsequence
  sequence s_lo_rd;
    reg_read && reg_addr == 12'hf73;
  endsequence
  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  chk_start_req: assert property (s_start |-> sample_req)
    else $error("start not passed to core");
  chk_busy_hold: assert property (s_start |=> conv_busy [*8])
    else $error("busy dropped early");
  chk_ctrl1_rsvd: assert property (reg_read && reg_addr == 12'hf71 |=> reg_rdata[6:3] == 4'h0)
    else $error("reserved control bits not zero");
  chk_amp_write: assert property (reg_write && reg_addr == 12'hf74
    |=> low_power_amp_on == !$past(reg_wdata[0]))
    else $error("amp enable polarity wrong");
  chk_amp_steady: assert property ($changed(low_power_amp_on)
    |-> $past(reg_write) && $past(reg_addr) == 12'hf74)
    else $error("amp power changed without write");
  chk_ref_onehot: assert property ($onehot0({ref_external, ref_int_1v0, ref_int_2v0}))
    else $error("several references on");
  chk_buf_mode: assert property (!input_buffer_select[1]
    |-> {buf_diff, buf_unity} == {input_buffer_select[2], input_buffer_select[0]})
    else $error("buffer mode decode wrong");
  chk_lo_stable: assert property (s_lo_rd ##1 s_lo_rd
    |=> (reg_rdata & 8'hf9) == ($past(reg_rdata) & 8'hf9))
    else $error("low result changed between reads");
endmodule

/* verification/tb_abr_top.sv */
// Purpose: directed register-level test of the converter block
// Assumes: short conversion counts of 20 and 4
// Notes: reserved low result bits are masked
module tb_abr_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [14:0] FIRST_CYCLES = 15'h0014;
  localparam [14:0] REPEAT_CYCLES = 15'h0004;
  logic clock, arst_n, reg_write, reg_read, sample_ovf, stop_mode;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [12:0] sample_data;
  wire conv_busy, sample_req, low_power_amp_on, buf_unity, buf_diff;
  wire ref_external, ref_int_1v0, ref_int_2v0;
  wire [2:0] input_buffer_select;
  wire [15:0] se_switch, diff_switch;
  int error_cnt = 0;
  int tests_run = 0;
  abr_top #(.FIRST_CYCLES(FIRST_CYCLES), .REPEAT_CYCLES(REPEAT_CYCLES)) abr_top_i (
    .clock, .arst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .sample_data, .sample_ovf, .stop_mode, .conv_busy, .sample_req, .low_power_amp_on,
    .input_buffer_select, .buf_unity, .buf_diff, .ref_external, .ref_int_1v0,
    .ref_int_2v0, .se_switch, .diff_switch);
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock) reg_write <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock) reg_write <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock) reg_read <= 1;
    reg_addr <= a;
    @(posedge clock) reg_read <= 0;
    @(negedge clock) chk(reg_rdata & m, e);
  endtask
  // busy looked at one clock before and at the expected end of the conversion
  task automatic conv(input logic [7:0] cmd, input logic [12:0] s, input logic o,
      input int len);
    @(posedge clock) sample_data <= s;
    sample_ovf <= o;
    wr(12'hf70, cmd);
    repeat (len) @(negedge clock);
    chk(16'(conv_busy), 16'h0001);
    @(negedge clock) chk(16'(conv_busy), 16'h0000);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    error_cnt++;
    wrap_up;
  end
  initial begin
    {arst_n, reg_write, reg_read, sample_ovf, stop_mode} = 0;
    reg_addr = 0;
    reg_wdata = 0;
    sample_data = 0;
    repeat (3) @(posedge clock);
    arst_n <= 1;
    rd(12'hf71, 8'hff, 8'h80);
    chk(8'(ref_int_2v0), 8'h01);
    chk(8'(low_power_amp_on), 8'h00);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      wr(12'hf70, {1'b0, i[0], 6'h00});
      wr(12'hf71, {i[1], 7'h00});
      @(negedge clock);
      chk({5'h00, ref_external, ref_int_1v0, ref_int_2v0}, i == 3 ? 8'h00 : 8'h04 >> i);
    end
    for (int c = 0; c < 8; c++) begin
      wr(12'hf71, 8'(c));
      rd(12'hf71, 8'hff, 8'(c));
      if (c < 2 || c == 4 || c == 5) chk({buf_diff, buf_unity}, {c[2], c[0]});
      chk(16'(input_buffer_select), 16'(c));
      chk(se_switch, (c == 0 || c == 1) ? 16'h0001 : 16'h0000);
      chk(diff_switch, (c == 4 || c == 5) ? 16'h0001 : 16'h0000);
    end
    wr(12'hf70, 8'h03);
    wr(12'hf71, 8'h04);
    @(negedge clock) chk(diff_switch, 16'h0008);
    chk(se_switch, 16'h0000);
    wr(12'hf71, 8'h87);
    rd(12'hf71, 8'hff, 8'h87);
    $display("mode decode done");
    wr(12'hf74, 8'h00);
    @(negedge clock) chk(8'(low_power_amp_on), 8'h01);
    @(posedge clock) stop_mode <= 1;
    repeat (3) @(negedge clock);
    chk(8'(low_power_amp_on), 8'h01);
    wr(12'hf71, 8'h81);
    conv(8'h80, 13'h0123, 0, FIRST_CYCLES);
    chk(8'(buf_unity), 8'h01);
    chk(se_switch, 16'h0001);
    chk(8'(low_power_amp_on), 8'h01);
    wr(12'hf74, 8'h01);
    @(negedge clock) chk(8'(low_power_amp_on), 8'h00);
    @(posedge clock) stop_mode <= 0;
    $display("amplifier done");
    conv(8'h80, 13'h1abc, 1, FIRST_CYCLES);
    rd(12'hf72, 8'hff, 8'hd5);
    rd(12'hf73, 8'hf9, 8'he1);
    wr(12'hf72, 8'h00);
    wr(12'hf73, 8'h00);
    rd(12'hf73, 8'hf9, 8'he1);
    @(posedge clock) reg_read <= 1;
    reg_addr <= 12'hf73;
    @(posedge clock);
    @(posedge clock) reg_read <= 0;
    conv(8'h80, 13'h0055, 0, FIRST_CYCLES);
    rd(12'hf73, 8'hf9, 8'he1);
    rd(12'hf72, 8'hff, 8'h02);
    rd(12'hf73, 8'hf9, 8'ha8);
    wr(12'hf71, 8'h80);
    conv(8'h8e, 13'h0055, 0, 2 * FIRST_CYCLES);
    $display("single shot done");
    @(posedge clock) sample_data <= 13'h1000;
    wr(12'hf70, 8'h90);
    repeat (30) @(posedge clock);
    rd(12'hf72, 8'hff, 8'h80);
    @(posedge clock) sample_data <= 13'h0fff;
    repeat (8) @(posedge clock);
    rd(12'hf72, 8'hff, 8'h7f);
    rd(12'hf73, 8'hf9, 8'hf8);
    rd(12'hf7f, 8'hff, 8'h00);
    $display("continuous done");
    wrap_up;
  end
endmodule
bind abr_top abr_top_checker #(.FIRST_CYCLES(FIRST_CYCLES), .REPEAT_CYCLES(REPEAT_CYCLES))
  abr_top_checker_i (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .conv_busy, .sample_req, .low_power_amp_on, .input_buffer_select,
  .buf_unity, .buf_diff, .ref_external, .ref_int_1v0, .ref_int_2v0);
